// ---- adc_ctrl_map.svh ----
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// register indexes; byte address is four times the index
`define IDX_MODE      8'hB1
`define IDX_RES_HI    8'hB2
`define IDX_CLK_RES   8'hB3
`define IDX_IRQ       8'hB4
`define IDX_MSB       9
`define IDX_LSB       2

`define MODE_RESET    8'h00
`define CLKRES_RESET  3'h0
`define IRQ_RESET     2'h0
`define CLKRES_MSB    6
`define CLKRES_LSB    4
`define IRQ_MSB       1

// converter clock dividers per select code
`define DIV_CODE_00   5'h10
`define DIV_CODE_01   5'h08
`define DIV_CODE_10   5'h01
`define DIV_CODE_11   5'h02
`define QUARTER_LAST  2'h3
`define QUARTERS      11'h004

// conversion slots of (converter clock / 4)
`define LAST_SLOT_12  4'hF
`define LAST_SLOT_8   4'hB
`define FIRST_DECIDE  4'h4
`define PRE_DECIDE    4'h3
`define BIT_BASE      4'hF
`define SLOTS_12      11'h010
`define SLOTS_8       11'h00C

`endif

// ---- sar_adc_pkg.sv ----
`default_nettype none
package sar_adc_pkg;
  typedef struct packed {
    logic       en;
    logic       start;
    logic       eoc;
    logic       gce;
    logic       extref;
    logic [2:0] sel;
  } mode_t;

  typedef struct packed {
    logic cks1;
    logic res12;
    logic cks0;
  } clkres_t;

  typedef struct packed {
    logic ien;
    logic flag;
  } irq_ctl_t;

  typedef struct packed {
    logic       write;
    logic [7:0] idx;
  } bus_req_t;

  typedef enum logic {ST_IDLE, ST_RUN} conv_state_t;
endpackage
`default_nettype wire

// ---- sar_adc_control.sv ----
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_map.svh"

// Notes on behaviour
// RQ1 - enable bit powers the converter
// RQ2 - start bit begins; hardware clears it when done
// RQ3 - writing start zero aborts conversion
// RQ4 - conversion needs enable and start both set
// RQ5 - end flag low while busy, set at end
// RQ6 - completion sets end flag, irq flag, result
// RQ7 - enabled irq flag raises interrupt request
// RQ8 - software clears the irq flag itself
// RQ9 - channel enable connects selected input, else none
// RQ10 - three-bit select picks input zero to seven
// RQ11 - reference bit picks supply or external pin
// RQ12 - clock select divides by 16,8,1,2
// RQ13 - resolution bit picks 8 or 12 bits
// RQ14 - result split: high byte, low nibble
// RQ15 - 8-bit result sits in high byte
// RQ16 - result registers read-only, unset after reset
// RQ17 - straight binary code of 4096 steps
// RQ18 - software configures everything before start
// RQ19 - software disables converter before power saving
// RQ20 - conversion lasts 16 or 12 quarter-clock periods
// RQ21 - software waits warm-up before first start
// RQ22 - both result parts update together
module sar_adc_control (
  input  wire logic                       clk_i,               // 10 MHz clock
  input  wire logic                       reset_n_i,           // async reset
  input  wire logic                       hsel_i,              // slave select
  input  wire logic [31:0]                haddr_i,             // byte address
  input  wire logic [1:0]                 htrans_i,            // transfer type
  input  wire logic                       hwrite_i,            // write access
  input  wire logic [2:0]                 hsize_i,             // word only
  input  wire logic [31:0]                hwdata_i,            // write data
  input  wire logic                       hready_i,            // bus ready
  output logic      [31:0]                hrdata_o,            // read data
  output logic                            hreadyout_o,         // slave ready
  output logic                            hresp_o,             // always okay
  input  wire logic                       cmp_i,               // input >= dac code
  output logic                            converter_power_o,   // analog power
  output logic      [7:0]                 channel_connect_o,   // one-hot switch
  output logic                            ext_reference_o,     // external ref
  output logic                            sample_o,            // sampling phase
  output logic      [11:0]                dac_code_o,          // sar trial code
  output logic                            irq_req_o            // interrupt request
);
  import sar_adc_pkg::*;

  mode_t       mode_r;
  clkres_t     clkres_r;
  irq_ctl_t    irq_r;
  conv_state_t state_r;
  bus_req_t    dp_req_r;
  logic        dp_valid_r;
  logic        rd_wait_r;
  logic [7:0]  res_hi_r;
  logic [3:0]  res_lo_r;
  logic [11:0] sar_r;
  logic [11:0] sar_nxt;
  logic [4:0]  ck_cnt_r;
  logic [4:0]  div_sel;
  logic [1:0]  quarter_r;
  logic [3:0]  slot_r;
  logic [3:0]  last_slot;
  logic [3:0]  bit_idx;
  logic [10:0] run_cnt_r;
  logic [7:0]  rd_mux;
  logic        accept;
  logic        wr_mode;
  logic        wr_clk;
  logic        wr_irq;
  logic        ck_tick;
  logic        slot_tick;
  logic        done;
  logic        begin_conv;
  logic        abort;

  // bus slave: reads take one wait state so they see the latest write
  assign accept      = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = !(dp_valid_r && !dp_req_r.write && !rd_wait_r);
  assign hresp_o     = 1'b0;
  assign wr_mode     = dp_valid_r && dp_req_r.write && dp_req_r.idx == `IDX_MODE;
  assign wr_clk      = dp_valid_r && dp_req_r.write && dp_req_r.idx == `IDX_CLK_RES;
  assign wr_irq      = dp_valid_r && dp_req_r.write && dp_req_r.idx == `IDX_IRQ;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dp_valid_r <= 1'b0;
      dp_req_r   <= '0;
    end else if (hreadyout_o) begin
      dp_valid_r <= accept;
      dp_req_r   <= '{write: hwrite_i, idx: haddr_i[`IDX_MSB:`IDX_LSB]};
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (dp_req_r.idx)
      `IDX_MODE:    rd_mux = mode_r;
      `IDX_RES_HI:  rd_mux = res_hi_r; // RQ16
      `IDX_CLK_RES: rd_mux = {1'b0, clkres_r, res_lo_r};
      `IDX_IRQ:     rd_mux = {6'h00, irq_r};
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_wait_r <= 1'b0;
      hrdata_o  <= 32'h0000_0000;
    end else begin
      rd_wait_r <= !hreadyout_o;
      if (!hreadyout_o) begin
        hrdata_o <= {24'h000000, rd_mux};
      end
    end
  end

  // control and status
  assign begin_conv = state_r == ST_IDLE && mode_r.en && mode_r.start; // RQ4
  assign abort      = state_r == ST_RUN && (!mode_r.en || !mode_r.start); // RQ3 RQ1

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r <= mode_t'(`MODE_RESET);
    end else begin
      if (wr_mode) begin
        mode_r <= mode_t'(hwdata_i[7:0]);
      end else if (done) begin
        mode_r.start <= 1'b0; // RQ2
      end
      if (done) begin
        mode_r.eoc <= 1'b1; // RQ5 RQ6
      end else if (begin_conv) begin
        mode_r.eoc <= 1'b0; // RQ5
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clkres_r <= clkres_t'(`CLKRES_RESET);
    end else if (wr_clk) begin
      clkres_r <= clkres_t'(hwdata_i[`CLKRES_MSB:`CLKRES_LSB]);
    end
  end

  // interrupt flag: hardware set wins over a software clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_r <= irq_ctl_t'(`IRQ_RESET);
    end else begin
      if (wr_irq) begin
        irq_r <= irq_ctl_t'(hwdata_i[`IRQ_MSB:0]); // RQ8
      end
      if (done) begin
        irq_r.flag <= 1'b1; // RQ6
      end
    end
  end

  assign irq_req_o = irq_r.flag && irq_r.ien; // RQ7

  // converter clock and slot timing
  always_comb begin
    case ({clkres_r.cks1, clkres_r.cks0}) // RQ12
      2'b00:   div_sel = `DIV_CODE_00;
      2'b01:   div_sel = `DIV_CODE_01;
      2'b10:   div_sel = `DIV_CODE_10;
      default: div_sel = `DIV_CODE_11;
    endcase
  end

  assign last_slot = clkres_r.res12 ? `LAST_SLOT_12 : `LAST_SLOT_8; // RQ13 RQ20
  assign ck_tick   = state_r == ST_RUN && ck_cnt_r == div_sel - 5'h01;
  assign slot_tick = ck_tick && quarter_r == `QUARTER_LAST;
  assign done      = state_r == ST_RUN && slot_tick && slot_r == last_slot
                     && mode_r.en && mode_r.start; // RQ20

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (begin_conv) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (abort || done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ck_cnt_r  <= 5'h00;
      quarter_r <= 2'h0;
      slot_r    <= 4'h0;
      run_cnt_r <= 11'h000;
    end else if (state_r != ST_RUN) begin
      ck_cnt_r  <= 5'h00;
      quarter_r <= 2'h0;
      slot_r    <= 4'h0;
      run_cnt_r <= 11'h000;
    end else begin
      run_cnt_r <= run_cnt_r + 11'h001;
      ck_cnt_r  <= ck_tick ? 5'h00 : ck_cnt_r + 5'h01;
      if (ck_tick) begin
        quarter_r <= quarter_r + 2'h1;
      end
      if (slot_tick) begin
        slot_r <= slot_r + 4'h1;
      end
    end
  end

  // successive approximation, msb first, straight binary code
  assign bit_idx = `BIT_BASE - slot_r;

  always_comb begin
    sar_nxt = sar_r;
    if (slot_r == `PRE_DECIDE) begin
      sar_nxt[11] = 1'b1;
    end else if (slot_r >= `FIRST_DECIDE) begin
      sar_nxt[bit_idx] = cmp_i; // RQ17
      if (slot_r != last_slot) begin
        sar_nxt[bit_idx - 4'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sar_r <= 12'h000;
    end else if (begin_conv) begin
      sar_r <= 12'h000;
    end else if (slot_tick) begin
      sar_r <= sar_nxt;
    end
  end

  // result has no reset; both parts load on the same edge as the end flag
  always_ff @(posedge clk_i) begin
    if (done) begin
      res_hi_r <= sar_nxt[11:4]; // RQ14 RQ15 RQ22
      res_lo_r <= sar_nxt[3:0]; // RQ14 RQ22
    end
  end

  // analog side controls
  assign converter_power_o = mode_r.en; // RQ1
  assign ext_reference_o   = mode_r.extref; // RQ11
  assign sample_o          = state_r == ST_RUN && slot_r < `FIRST_DECIDE;
  assign dac_code_o        = sar_r;

  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_chan
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          channel_connect_o[ch] <= 1'b0;
        end else begin
          channel_connect_o[ch] <= mode_r.gce && mode_r.sel == 3'(ch); // RQ9 RQ10
        end
      end
    end
  endgenerate

  // checks; result_loaded_r keeps the unset result out of the stability check
  logic [10:0] expect_len;
  logic        result_loaded_r;
  assign expect_len = {6'h00, div_sel} * `QUARTERS
                      * (clkres_r.res12 ? `SLOTS_12 : `SLOTS_8);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_loaded_r <= 1'b0;
    end else if (done) begin
      result_loaded_r <= 1'b1;
    end
  end

  chk_run_needs_en: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ4
    state_r == ST_IDLE && !(mode_r.en && mode_r.start) |=> state_r == ST_IDLE)
    else $error("conversion began without enable and start");
  chk_eoc_low_busy: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ5
    $past(state_r) == ST_RUN && state_r == ST_RUN && !$past(wr_mode) |-> !mode_r.eoc)
    else $error("end flag high during conversion");
  chk_done_flags: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ6
    done && !wr_mode |=> mode_r.eoc && !mode_r.start && irq_r.flag && state_r == ST_IDLE)
    else $error("completion did not set flags");
  chk_conv_length: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ20
    done |-> run_cnt_r == expect_len - 11'h001)
    else $error("conversion length wrong");
  chk_irq_raise: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ7
    done && irq_r.ien && !wr_irq ##1 !wr_irq |-> irq_req_o ##1 irq_req_o)
    else $error("interrupt request not raised");
  chk_stop_abort: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ3
    state_r == ST_RUN && wr_mode && !hwdata_i[6] |=> ##1 state_r == ST_IDLE)
    else $error("start clear did not stop conversion");
  chk_result_pair: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ22
    done |=> res_hi_r == $past(sar_nxt[11:4]) && res_lo_r == $past(sar_nxt[3:0]))
    else $error("result parts not loaded together");
  chk_result_ro: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ16
    result_loaded_r && !done |=> $stable(res_hi_r) && $stable(res_lo_r))
    else $error("result changed without completion");
  chk_channel_map: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ9
    ##1 channel_connect_o == ($past(mode_r.gce) ? 8'h01 << $past(mode_r.sel) : 8'h00))
    else $error("channel switch does not follow select");

  cov_done_12: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    done && clkres_r.res12);
  cov_done_8: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    done && !clkres_r.res12);
  cov_abort: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    abort);
  cov_irq: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(irq_req_o));
endmodule
`default_nettype wire

// ---- analog_inputs_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module analog_inputs_model (
  input  wire logic             clk_i,      // system clock
  input  wire logic [7:0]       connect_i,  // one-hot input switch
  input  wire logic [11:0]      dac_i,      // trial code
  input  wire logic [7:0][11:0] level_i,    // input level per channel
  output logic                  cmp_o       // input at or above trial code
);
  logic        tog_r = 1'b0;
  logic [11:0] lvl;
  always_ff @(posedge clk_i) tog_r <= ~tog_r;
  always_comb begin
    lvl = 12'h000;
    for (int k = 0; k < 8; k++) if (connect_i[k]) lvl = level_i[k];
  end
  // a disconnected comparator floats, so it shows a level that keeps changing
  assign cmp_o = (connect_i == 8'h00) ? tog_r : (lvl >= dac_i);
endmodule
`default_nettype wire

// ---- sar_adc_control_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_bench;
  logic             clk_i = 1'b0;
  logic             reset_n_i = 1'b0;
  logic             hsel = 1'b0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0;
  logic [31:0]      hrdata;
  logic             hready;
  logic             cmp;
  logic             power;
  logic [7:0]       chan;
  logic             extref;
  logic [11:0]      dac;
  logic             irq;
  logic             hresp;
  logic             sample;
  logic [7:0][11:0] level = '0;
  logic [31:0]      rd;
  logic [11:0]      e;
  logic [2:0]       ch;
  logic [1:0]       cks;
  logic             r12;
  int               errors = 0;
  int               checks = 0;
  int               cyc = 0;
  int               t0;

  sar_adc_control sar_adc_control_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .cmp_i(cmp),
    .converter_power_o(power), .channel_connect_o(chan), .ext_reference_o(extref),
    .sample_o(sample), .dac_code_o(dac), .irq_req_o(irq));
  analog_inputs_model analog_inputs_model_i (.clk_i(clk_i), .connect_i(chan), .dac_i(dac),
    .level_i(level), .cmp_o(cmp));

  initial forever #50 clk_i = ~clk_i;

  task automatic report_and_stop();
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] x);
    xfer(1'b0, idx, 8'h00);
    chk(nm, {24'h0, x}, rd);
  endtask

  function automatic int conv_cycles(input logic [1:0] c, input logic r);
    int d;
    case (c)
      2'b00: d = 16;
      2'b01: d = 8;
      2'b10: d = 1;
      default: d = 2;
    endcase
    return d * 4 * (r ? 16 : 12);
  endfunction

  function automatic logic [11:0] exp_code(input logic [11:0] lvl, input logic r);
    return r ? lvl : {lvl[11:4], 4'h0};
  endfunction

  initial begin
    void'($urandom(77964));
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdc("mode reset", 8'hB1, 8'h00);
    xfer(1'b0, 8'hB3, 8'h00);
    chk("clkres reset", 32'h0, rd & 32'hF0);
    wr(8'h20, 8'hFF);
    rdc("unmapped", 8'h20, 8'h00);
    for (int s = 0; s < 16; s++) begin
      wr(8'hB1, 8'h80 | (s < 8 ? 8'h10 : 8'h00) | {4'h0, s[0], s[2:0]});
      repeat (2) @(posedge clk_i);
      chk("connect", s < 8 ? 32'h1 << s[2:0] : 32'h0, {24'h0, chan});
      chk("ext ref", {31'h0, s[0]}, {31'h0, extref});
      chk("power", 32'h1, {31'h0, power});
    end
    repeat (1000) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      cks = 2'(i);
      r12 = i[2];
      ch = 3'(i);
      level[ch] <= (i == 0) ? 12'h000 : (i == 7) ? 12'hFFF : 12'($urandom);
      wr(8'hB3, {1'b0, cks[1], r12, cks[0], 4'h0});
      wr(8'hB4, 8'h02);
      wr(8'hB1, 8'hD0 | {5'h0, ch});
      t0 = cyc;
      repeat (2) @(posedge clk_i);
      chk("sampling", 32'h1, {31'h0, sample});
      rdc("busy mode", 8'hB1, 8'hD0 | {5'h0, ch});
      while (irq !== 1'b1) @(posedge clk_i);
      chk("sampling idle", 32'h0, {31'h0, sample});
      chk("duration", conv_cycles(cks, r12) + 2, cyc - t0);
      e = exp_code(level[ch], r12);
      rdc("done mode", 8'hB1, 8'hB0 | {5'h0, ch});
      rdc("result high", 8'hB2, e[11:4]);
      rdc("result low", 8'hB3, {1'b0, cks[1], r12, cks[0], e[3:0]});
      wr(8'hB4, 8'h01);
      @(posedge clk_i);
      chk("masked irq", 32'h0, {31'h0, irq});
      wr(8'hB4, 8'h02);
      @(posedge clk_i);
      chk("cleared irq", 32'h0, {31'h0, irq});
    end
    wr(8'hB3, 8'h20);
    wr(8'hB1, 8'hD2);
    repeat (30) @(posedge clk_i);
    wr(8'hB1, 8'h92);
    repeat (1100) @(posedge clk_i);
    chk("abort irq", 32'h0, {31'h0, irq});
    rdc("abort mode", 8'hB1, 8'h92);
    rdc("abort result", 8'hB2, 8'hFF);
    wr(8'hB1, 8'h52);
    repeat (1100) @(posedge clk_i);
    chk("no enable irq", 32'h0, {31'h0, irq});
    chk("power off", 32'h0, {31'h0, power});
    wr(8'hB2, 8'h00);
    chk("ro write okay", 32'h0, {31'h0, hresp});
    rdc("result high ro", 8'hB2, 8'hFF);
    wr(8'hB3, 8'h20);
    rdc("result low ro", 8'hB3, 8'h2F);
    wr(8'hB1, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
